// ==== caf_pkg.sv ====
package caf_pkg;
   // ****************************************************************
   // register map
   // ****************************************************************
   localparam logic [7:0] CAF_CTRL5_OFFSET = 8'h00;
   localparam int CAF_ADDR_W = 8;
   localparam int CAF_DATA_W = 32;
   localparam int CAF_STRB_W = 4;

   // ****************************************************************
   // field layout
   // ****************************************************************
   localparam int CAF_MASK_W = 2;
   localparam int CAF_BUF_W = 5;
   localparam int CAF_SLOT_W = 8;
   localparam int CAF_MASK_N = 4;
   localparam int CAF_EN_POS = 7;
   localparam int CAF_MASK_LSB = 5;
   localparam int CAF_BUF_LSB = 0;
   localparam int CAF_F20_LSB = 0;
   localparam int CAF_F21_LSB = 8;
   localparam int CAF_F20_LANE = 0;
   localparam int CAF_F21_LANE = 1;

   // ****************************************************************
   // reset values and bus answers
   // ****************************************************************
   localparam logic CAF_EN_RESET = 1'b0;
   localparam logic [CAF_MASK_W-1:0] CAF_MASK_RESET = 2'h0;
   localparam logic [CAF_BUF_W-1:0] CAF_BUF_RESET = 5'h00;
   localparam logic [1:0] CAF_RESP_OKAY = 2'h0;
   localparam logic [1:0] CAF_RESP_SLVERR = 2'h2;
   localparam logic [CAF_DATA_W-1:0] CAF_RDATA_ZERO = 32'h0000_0000;
endpackage

// ==== caf_filter_slot.sv ====
`timescale 1ns/1ps
module caf_filter_slot
   import caf_pkg::*;
#(
   parameter int MASK_W = CAF_MASK_W,
   parameter int BUF_W = CAF_BUF_W
) (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // settings write
   input wire logic wr,
   input wire logic [CAF_SLOT_W-1:0] wbyte,
   // settings out
   output logic enable,
   output logic [MASK_W-1:0] mask_choice,
   output logic [BUF_W-1:0] buffer_choice,
   output logic [CAF_MASK_N-1:0] mask_onehot,
   output logic [CAF_SLOT_W-1:0] rbyte
);
   // ****************************************************************
   // enable flag
   // ****************************************************************
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         enable <= CAF_EN_RESET;
      end else if (wr) begin
         enable <= wbyte[CAF_EN_POS];
      end
   end

   // ****************************************************************
   // mask and buffer choice, locked while enabled
   // ****************************************************************
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         mask_choice <= CAF_MASK_RESET;
         buffer_choice <= CAF_BUF_RESET;
      end else if (wr && !enable) begin
         mask_choice <= wbyte[CAF_MASK_LSB +: MASK_W];
         buffer_choice <= wbyte[CAF_BUF_LSB +: BUF_W];
      end
   end

   // ****************************************************************
   // mask decode and readback
   // ****************************************************************
   always_comb begin
      mask_onehot = '0;
      mask_onehot[mask_choice] = 1'b1;
      rbyte = '0;
      rbyte[CAF_EN_POS] = enable;
      rbyte[CAF_MASK_LSB +: MASK_W] = mask_choice;
      rbyte[CAF_BUF_LSB +: BUF_W] = buffer_choice;
   end

   // ****************************************************************
   // checks
   // ****************************************************************
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   chk_locked_keeps_choice: assert property (
      wr && enable |=> $stable(mask_choice) && $stable(buffer_choice))
      else $error("locked filter settings changed");
   chk_unlocked_takes_choice: assert property (
      wr && !enable |=> mask_choice == $past(wbyte[CAF_MASK_LSB +: MASK_W])
         && buffer_choice == $past(wbyte[CAF_BUF_LSB +: BUF_W]))
      else $error("unlocked filter write not stored");
   chk_enable_follows: assert property (
      wr |=> enable == $past(wbyte[CAF_EN_POS]))
      else $error("enable write not stored");
   chk_mask_decode: assert property (
      $onehot(mask_onehot) && mask_onehot[mask_choice])
      else $error("mask decode wrong");
   chk_idle_holds: assert property (
      !wr |=> $stable(enable) && $stable(mask_choice)
         && $stable(buffer_choice))
      else $error("settings changed without write");
endmodule

// ==== caf_top.sv ====
// Chosen here: the AXI4-Lite register port and the address map.
`timescale 1ns/1ps
module caf_top
   import caf_pkg::*;
#(
   parameter int MASK_W = CAF_MASK_W,
   parameter int BUF_W = CAF_BUF_W
) (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // axi4-lite write address
   input wire logic awvalid,
   output logic awready,
   input wire logic [CAF_ADDR_W-1:0] awaddr,
   input wire logic [2:0] awprot,
   // axi4-lite write data
   input wire logic wvalid,
   output logic wready,
   input wire logic [CAF_DATA_W-1:0] wdata,
   input wire logic [CAF_STRB_W-1:0] wstrb,
   // axi4-lite write response
   output logic bvalid,
   input wire logic bready,
   output logic [1:0] bresp,
   // axi4-lite read address
   input wire logic arvalid,
   output logic arready,
   input wire logic [CAF_ADDR_W-1:0] araddr,
   input wire logic [2:0] arprot,
   // axi4-lite read data
   output logic rvalid,
   input wire logic rready,
   output logic [CAF_DATA_W-1:0] rdata,
   output logic [1:0] rresp,
   // filter 20 settings
   output logic filter20_enable,
   output logic [MASK_W-1:0] filter20_mask_choice,
   output logic [CAF_MASK_N-1:0] filter20_mask_onehot,
   output logic [BUF_W-1:0] filter20_buffer_choice,
   // filter 21 settings
   output logic filter21_enable,
   output logic [MASK_W-1:0] filter21_mask_choice,
   output logic [CAF_MASK_N-1:0] filter21_mask_onehot,
   output logic [BUF_W-1:0] filter21_buffer_choice,
   // match steering
   input wire logic filter20_hit,
   input wire logic filter21_hit,
   output logic store_valid,
   output logic [BUF_W-1:0] store_buffer
);
   // ****************************************************************
   // write channel capture
   // ****************************************************************
   logic aw_held;
   logic w_held;
   logic [CAF_ADDR_W-1:0] aw_addr;
   logic [CAF_DATA_W-1:0] w_data;
   logic [CAF_STRB_W-1:0] w_strb;
   logic do_write;
   logic wr_hit;
   logic wr20;
   logic wr21;
   logic [CAF_SLOT_W-1:0] rbyte20;
   logic [CAF_SLOT_W-1:0] rbyte21;
   logic [CAF_DATA_W-1:0] ctrl5_value;

   assign awready = !aw_held && !bvalid;
   assign wready = !w_held && !bvalid;
   assign do_write = aw_held && w_held && !bvalid;
   assign wr_hit = aw_addr == CAF_CTRL5_OFFSET;
   assign wr20 = do_write && wr_hit && w_strb[CAF_F20_LANE];
   assign wr21 = do_write && wr_hit && w_strb[CAF_F21_LANE];

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held <= 1'b0;
         aw_addr <= '0;
      end else if (awvalid && awready) begin
         aw_held <= 1'b1;
         aw_addr <= awaddr;
      end else if (do_write) begin
         aw_held <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_held <= 1'b0;
         w_data <= '0;
         w_strb <= '0;
      end else if (wvalid && wready) begin
         w_held <= 1'b1;
         w_data <= wdata;
         w_strb <= wstrb;
      end else if (do_write) begin
         w_held <= 1'b0;
      end
   end

   // ****************************************************************
   // write response
   // ****************************************************************
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid <= 1'b0;
         bresp <= CAF_RESP_OKAY;
      end else if (do_write) begin
         bvalid <= 1'b1;
         bresp <= wr_hit ? CAF_RESP_OKAY : CAF_RESP_SLVERR;
      end else if (bready) begin
         bvalid <= 1'b0;
      end
   end

   // ****************************************************************
   // filter slots
   // ****************************************************************
   caf_filter_slot #(
      .MASK_W(MASK_W),
      .BUF_W(BUF_W)
   ) u_filter20 (
      .aclk(aclk),
      .aresetn(aresetn),
      .wr(wr20),
      .wbyte(w_data[CAF_F20_LSB +: CAF_SLOT_W]),
      .enable(filter20_enable),
      .mask_choice(filter20_mask_choice),
      .buffer_choice(filter20_buffer_choice),
      .mask_onehot(filter20_mask_onehot),
      .rbyte(rbyte20)
   );

   caf_filter_slot #(
      .MASK_W(MASK_W),
      .BUF_W(BUF_W)
   ) u_filter21 (
      .aclk(aclk),
      .aresetn(aresetn),
      .wr(wr21),
      .wbyte(w_data[CAF_F21_LSB +: CAF_SLOT_W]),
      .enable(filter21_enable),
      .mask_choice(filter21_mask_choice),
      .buffer_choice(filter21_buffer_choice),
      .mask_onehot(filter21_mask_onehot),
      .rbyte(rbyte21)
   );

   always_comb begin
      ctrl5_value = CAF_RDATA_ZERO;
      ctrl5_value[CAF_F20_LSB +: CAF_SLOT_W] = rbyte20;
      ctrl5_value[CAF_F21_LSB +: CAF_SLOT_W] = rbyte21;
   end

   // ****************************************************************
   // read channel
   // ****************************************************************
   assign arready = !rvalid;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid <= 1'b0;
         rdata <= CAF_RDATA_ZERO;
         rresp <= CAF_RESP_OKAY;
      end else if (arvalid && arready) begin
         rvalid <= 1'b1;
         if (araddr == CAF_CTRL5_OFFSET) begin
            rdata <= ctrl5_value;
            rresp <= CAF_RESP_OKAY;
         end else begin
            rdata <= CAF_RDATA_ZERO;
            rresp <= CAF_RESP_SLVERR;
         end
      end else if (rready) begin
         rvalid <= 1'b0;
      end
   end

   // ****************************************************************
   // match steering, filter 20 first
   // ****************************************************************
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         store_valid <= 1'b0;
         store_buffer <= CAF_BUF_RESET;
      end else begin
         store_valid <= (filter20_hit && filter20_enable)
            || (filter21_hit && filter21_enable);
         if (filter20_hit && filter20_enable) begin
            store_buffer <= filter20_buffer_choice;
         end else if (filter21_hit && filter21_enable) begin
            store_buffer <= filter21_buffer_choice;
         end
      end
   end

   // ****************************************************************
   // checks
   // ****************************************************************
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   chk_disabled_no_store: assert property (
      !(filter20_hit && filter20_enable) && !(filter21_hit && filter21_enable)
      |=> !store_valid)
      else $error("disabled filter produced a store");
   chk_enabled_store: assert property (
      filter20_hit && filter20_enable
      |=> store_valid && store_buffer == $past(filter20_buffer_choice))
      else $error("filter 20 match not steered");
   chk_f21_store: assert property (
      filter21_hit && filter21_enable && !(filter20_hit && filter20_enable)
      |=> store_valid && store_buffer == $past(filter21_buffer_choice))
      else $error("filter 21 match not steered");
   chk_f21_layout: assert property (
      wr21 |=> filter21_enable == $past(w_data[15]))
      else $error("filter 21 enable not at bit 15");
   chk_f20_layout: assert property (
      wr20 && !filter20_enable |=> filter20_mask_choice == $past(w_data[6:5])
         && filter20_buffer_choice == $past(w_data[4:0]))
      else $error("filter 20 fields misplaced");
   chk_locked_write: assert property (
      wr21 && filter21_enable |=> $stable(filter21_buffer_choice)
         && filter21_enable == $past(w_data[15]))
      else $error("locked filter 21 write misbehaved");
   chk_write_answer: assert property (
      do_write |=> bvalid)
      else $error("write response missing");
   chk_resp_taken: assert property (
      bvalid && bready |=> !bvalid)
      else $error("write response not released");
   chk_read_taken: assert property (
      rvalid && rready |=> !rvalid)
      else $error("read answer not released");
   chk_read_back: assert property (
      arvalid && arready && araddr == CAF_CTRL5_OFFSET && !do_write
      |=> rvalid && rdata[15] == filter21_enable
         && rdata[7] == filter20_enable && rdata[31:16] == 16'h0000)
      else $error("readback layout wrong");
endmodule

// ==== caf_match_model.sv ====
`timescale 1ns/1ps
// ****************************************************************
// matching logic stand-in: one-cycle hit pulses
// ****************************************************************
module caf_match_model (
   // clock
   input wire logic aclk,
   // hits
   output logic hit20,
   output logic hit21
);
   initial begin
      hit20 = 1'b0;
      hit21 = 1'b0;
   end
   // pulse launched after an edge, dropped at the next
   task automatic fire(input logic a, input logic b);
      hit20 <= a;
      hit21 <= b;
      @(posedge aclk);
      hit20 <= 1'b0;
      hit21 <= 1'b0;
   endtask
endmodule

// ==== test_caf_top.sv ====
`timescale 1ns/1ps
module test_caf_top;
   import caf_pkg::*;
   logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
   logic awready, wready, bvalid, arready, rvalid, store_valid;
   logic [7:0] awaddr, araddr;
   logic [2:0] awprot, arprot;
   logic [31:0] wdata, rdata, q;
   logic [3:0] wstrb, filter20_mask_onehot, filter21_mask_onehot;
   logic [1:0] bresp, rresp, r, filter20_mask_choice, filter21_mask_choice;
   logic [4:0] filter20_buffer_choice, filter21_buffer_choice, store_buffer;
   logic filter20_enable, filter21_enable, filter20_hit, filter21_hit;
   int err_count, total_checks;
   caf_top dut (.*);
   caf_match_model m (.aclk(aclk), .hit20(filter20_hit),
      .hit21(filter21_hit));
   // ****************************************************************
   // helpers
   // ****************************************************************
   initial begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end
   function automatic logic [7:0] slot(logic e, logic [1:0] k,
      logic [4:0] b);
      return {e, k, b};
   endfunction
   task automatic check(string n, logic [31:0] seen, logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("MISMATCH %s exp %h seen %h", n, exp, seen);
      end
   endtask
   task automatic wr(logic [7:0] a, logic [3:0] s, logic [31:0] d);
      int n;
      n = 0;
      awaddr <= a;
      wdata <= d;
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge aclk);
         n++;
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
      end while (!bvalid && n < 100);
      r = bresp;
      bready <= 1'b0;
      @(posedge aclk);
      if (n >= 100) err_count++;
   endtask
   task automatic rd(logic [7:0] a);
      int n;
      n = 0;
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge aclk);
         n++;
         if (arvalid && arready) arvalid <= 1'b0;
      end while (!rvalid && n < 100);
      q = rdata;
      r = rresp;
      rready <= 1'b0;
      @(posedge aclk);
      if (n >= 100) err_count++;
   endtask
   task automatic hit(logic a, logic b, logic ev, logic [4:0] eb);
      m.fire(a, b);
      @(posedge aclk);
      check("store_valid", store_valid, ev);
      check("store_buffer", store_buffer, eb);
   endtask
   task automatic stop_test;
      $display("checks %0d mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   // ****************************************************************
   // scenarios
   // ****************************************************************
   task automatic t_fields;
      logic [1:0] k;
      logic [4:0] b;
      logic [31:0] d;
      rd(CAF_CTRL5_OFFSET);
      check("reset value", q, 32'h0000_0000);
      for (int i = 0; i < 4; i++) begin
         k = i[1:0];
         b = 5'(i * 10);
         d = {16'h0000, slot(1'b0, ~k, ~b), slot(1'b0, k, b)};
         wr(CAF_CTRL5_OFFSET, 4'hf, d);
         check("bresp", r, CAF_RESP_OKAY);
         rd(CAF_CTRL5_OFFSET);
         check("readback", q, d);
         check("mask20", filter20_mask_choice, k);
         check("onehot20", filter20_mask_onehot, 4'h1 << k);
         check("mask21", filter21_mask_choice, 2'(~k));
         check("onehot21", filter21_mask_onehot, 4'h1 << 2'(~k));
         check("buf20", filter20_buffer_choice, b);
         check("buf21", filter21_buffer_choice, 5'(~b));
      end
   endtask
   task automatic t_lock;
      logic [31:0] a;
      a = {16'h0000, slot(1'b1, 2'h2, 5'h06), slot(1'b1, 2'h1, 5'h05)};
      wr(CAF_CTRL5_OFFSET, 4'hf, a);
      check("en20", filter20_enable, 1'b1);
      check("en21", filter21_enable, 1'b1);
      wr(CAF_CTRL5_OFFSET, 4'hf, 32'h0000_ffff);
      rd(CAF_CTRL5_OFFSET);
      check("locked", q, a);
      wr(CAF_CTRL5_OFFSET, 4'hf, 32'h0000_0000);
      rd(CAF_CTRL5_OFFSET);
      check("unlock", q, a & 32'h0000_7f7f);
      a = {16'h0000, slot(1'b0, 2'h3, 5'h09), slot(1'b0, 2'h0, 5'h03)};
      wr(CAF_CTRL5_OFFSET, 4'hf, a);
      wr(CAF_CTRL5_OFFSET, 4'h1, 32'h0000_7f7f);
      rd(CAF_CTRL5_OFFSET);
      check("lane", q, {a[31:8], 8'h7f});
      wr(8'h04, 4'hf, 32'h0000_0000);
      check("bresp bad", r, CAF_RESP_SLVERR);
      rd(8'h04);
      check("rresp bad", r, CAF_RESP_SLVERR);
      check("rdata bad", q, CAF_RDATA_ZERO);
      rd(CAF_CTRL5_OFFSET);
      check("kept", q, {a[31:8], 8'h7f});
   endtask
   task automatic t_match;
      a_en : begin
         wr(CAF_CTRL5_OFFSET, 4'hf,
            {16'h0000, slot(1'b1, 2'h0, 5'h19), slot(1'b1, 2'h0, 5'h07)});
      end
      hit(1'b0, 1'b1, 1'b1, 5'h19);
      hit(1'b1, 1'b1, 1'b1, 5'h07);
      wr(CAF_CTRL5_OFFSET, 4'hf, {16'h0000, slot(1'b1, 2'h0, 5'h19), 8'h00});
      check("en20 off", filter20_enable, 1'b0);
      hit(1'b1, 1'b0, 1'b0, 5'h07);
      hit(1'b0, 1'b1, 1'b1, 5'h19);
      @(posedge aclk);
      check("pulse end", store_valid, 1'b0);
   endtask
   task automatic t_reset;
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      check("en21 reset", filter21_enable, CAF_EN_RESET);
      check("store reset 2", store_valid, 1'b0);
      rd(CAF_CTRL5_OFFSET);
      check("reset again", q, CAF_RDATA_ZERO);
   endtask
   // ****************************************************************
   // main sequence and watchdog
   // ****************************************************************
   initial begin
      {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
      {awaddr, araddr, awprot, arprot} = 22'h000000;
      wdata = 32'h0000_0000;
      wstrb = 4'h0;
      err_count = 0;
      total_checks = 0;
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      check("en20 reset", filter20_enable, CAF_EN_RESET);
      check("store reset", store_valid, 1'b0);
      t_fields();
      t_lock();
      t_match();
      t_reset();
      stop_test();
   end
   initial begin
      repeat (3000) @(posedge aclk);
      err_count++;
      stop_test();
   end
endmodule
